// ### verification/cipc_core_model.sv
`timescale 1ns/1ps
// core stand-in: marks instruction ends and returns from service after each call
module cipc_core_model (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic irq_call,
    input  wire logic auto_reti,
    input  wire logic slow,
    input  wire logic reti_cmd,
    output logic      instr_end,
    output logic      core_reti
);
    logic [2:0] wait_reg;
    logic       call_q;
    // slow mode gives a boundary only every other cycle, like long instructions
    always @(posedge clk) begin
        call_q    <= irq_call;
        instr_end <= srst ? 1'b0 : (slow ? ~instr_end : 1'b1);
        if (srst) begin
            wait_reg <= 3'h0;
        end else if (call_q && !irq_call && auto_reti) begin
            wait_reg <= 3'h3;
        end else if (wait_reg != 3'h0) begin
            wait_reg <= wait_reg - 3'h1;
        end
        core_reti <= !srst && ((wait_reg == 3'h1) || reti_cmd);
    end
endmodule // cipc_core_model

// ### verification/cipc_ctrl_test.sv
`timescale 1ns/1ps
module cipc_ctrl_test;
    import cipc_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        ce = 1'b1;
    logic [7:0]  sfr_addr = 8'h00;
    logic        sfr_wr = 1'b0;
    logic [7:0]  sfr_wdata = 8'h00;
    logic        sfr_rd = 1'b0;
    logic [10:0] src_on = 11'h000;
    logic        auto_reti = 1'b1;
    logic        slow = 1'b0;
    logic        reti_cmd = 1'b0;
    logic [7:0]  sfr_rdata;
    logic [15:0] irq_vector;
    logic        instr_end, core_reti, irq_call, baud_double, stop_mode, idle_mode;
    logic        rd_pend, call_q;
    logic [3:0]  call_len = 4'h0;
    logic [7:0]  rd_q [$];
    logic [15:0] vec_q [$];
    logic [7:0]  d;
    int          call_cnt = 0;
    int          n_fail = 0;
    int          cmp_count = 0;
    int          seed = 23205;
    int          i;
    // register map incl. one unmapped place, and bits that hold
    localparam logic [7:0] reg_addr [0:9] = '{8'h87, 8'h9A, 8'hA8, 8'hB8, 8'h88,
        8'hA9, 8'hB9, 8'hC8, 8'hC0, 8'h80};
    localparam logic [7:0] reg_mask [0:9] = '{8'h8F, 8'h01, 8'hDF, 8'h7E, 8'hFF,
        8'h3F, 8'h3F, 8'h60, 8'h3E, 8'h00};
    // sources: ext0 ext1 tmr0 tmr1 ext2 ext3 ext4 ext5 ext6 ser0 ser1
    localparam logic [7:0] en_main [0:10] = '{8'h81, 8'h84, 8'h82, 8'h88, 8'h80, 8'h80,
        8'h80, 8'h80, 8'h80, 8'h90, 8'h80};
    localparam logic [7:0] en_ext [0:10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h04,
        8'h08, 8'h10, 8'h20, 8'h00, 8'h00};
    localparam logic [15:0] vec [0:10] = '{16'h0003, 16'h0013, 16'h000B, 16'h001B,
        16'h004B, 16'h0053, 16'h005B, 16'h0063, 16'h006B, 16'h0023, 16'h0083};

    always #12.5 clk = ~clk;

    cipc_ctrl dut (.clk(clk), .srst(srst), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .timer0_ovf(src_on[2]), .timer1_ovf(src_on[3]), .ext0_n(!src_on[0]),
        .ext1_n(!src_on[1]), .ext2_pin(!src_on[4]), .ext3_pin(src_on[5]),
        .ext4_in(src_on[6]), .ext5_in(src_on[7]), .ext6_in(src_on[8]),
        .serial0_flag(src_on[9]), .serial1_flag(src_on[10]), .instr_end(instr_end),
        .core_reti(core_reti), .irq_call(irq_call), .irq_vector(irq_vector),
        .baud_double(baud_double), .stop_mode(stop_mode), .idle_mode(idle_mode));
    cipc_core_model core (.clk(clk), .srst(srst), .irq_call(irq_call),
        .auto_reti(auto_reti), .slow(slow), .reti_cmd(reti_cmd),
        .instr_end(instr_end), .core_reti(core_reti));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        sfr_addr  <= a;
        sfr_wdata <= v;
        sfr_wr    <= 1'b1;
        @(posedge clk);
        sfr_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge clk);
        sfr_rd   <= 1'b0;
    endtask
    // bounded wait for the call counter, then its exact value
    task automatic wait_calls(input int n);
        for (int k = 0; k < 80 && call_cnt < n; k++) @(posedge clk);
        check(16'(call_cnt), 16'(n));
    endtask
    // timer inputs are pulses, the others stay active until the call shows
    task automatic fire(input int id, input int n);
        src_on[id] <= 1'b1;
        @(posedge clk);
        if (id == 2 || id == 3) src_on[id] <= 1'b0;
        wait_calls(n);
        src_on[id] <= 1'b0;
    endtask
    task automatic reti_pulse();
        @(posedge clk);
        reti_cmd <= 1'b1;
        @(posedge clk);
        reti_cmd <= 1'b0;
    endtask

    // scoreboard: oldest note against each read answer and each call
    always @(posedge clk) begin
        rd_pend  <= sfr_rd && ce;
        call_q   <= irq_call;
        call_len <= irq_call ? call_len + 4'h1 : 4'h0;
        if (rd_pend) check({8'h00, sfr_rdata}, {8'h00, rd_q.pop_front()});
        if (!irq_call && call_q) check({12'h000, call_len}, 16'h0006);
        if (irq_call && !call_q) begin
            call_cnt <= call_cnt + 1;
            check(irq_vector, vec_q.pop_front());
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        for (i = 0; i < 10; i++) rd(reg_addr[i], 8'h00);
        for (i = 0; i < 10; i++) begin
            d = 8'($random(seed));
            wr(reg_addr[i], d);
            rd(reg_addr[i], d & reg_mask[i]);
            if (i == 0) check({13'h0, baud_double, stop_mode, idle_mode},
                {13'h0, d[7], d[1], d[0]});
            wr(reg_addr[i], 8'h00);
        end
        $display("test registers done");
        // flags set with global enable off; ext5 stays masked throughout
        wr(8'hA8, 8'h02);
        wr(8'hB8, 8'h08);
        src_on[6] <= 1'b1;
        src_on[7] <= 1'b1;
        fire(2, 0);
        repeat (10) @(posedge clk);
        check(16'(call_cnt), 16'h0000);
        rd(8'h88, 8'h20);
        rd(8'hC0, 8'h18);
        vec_q.push_back(16'h000B);
        vec_q.push_back(16'h005B);
        wr(8'hA8, 8'h82);
        wait_calls(2);
        src_on[6] <= 1'b0;
        src_on[7] <= 1'b0;
        repeat (20) @(posedge clk);
        check(16'(call_cnt), 16'h0002);
        rd(8'h88, 8'h00);
        rd(8'hC0, 8'h10);
        wr(8'hC0, 8'h00);
        $display("test gating done");
        // every source once, edge modes, slow instruction ends
        wr(8'h88, 8'h05);
        wr(8'hC8, 8'h40);
        slow <= 1'b1;
        for (i = 0; i < 11; i++) begin
            wr(8'hA8, en_main[i]);
            wr(8'hB8, en_ext[i]);
            wr(8'h9A, {7'h00, i == 10});
            vec_q.push_back(vec[i]);
            fire(i, 3 + i);
        end
        rd(8'h88, 8'h05);
        repeat (14) @(posedge clk);
        $display("test sources done");
        // nesting: timer 0 raised one level over ext0
        auto_reti <= 1'b0;
        wr(8'hA9, 8'h02);
        wr(8'hA8, 8'h83);
        vec_q.push_back(16'h0003);
        fire(0, 14);
        repeat (2) @(posedge clk);
        src_on[0] <= 1'b1;
        repeat (2) @(posedge clk);
        src_on[0] <= 1'b0;
        vec_q.push_back(16'h000B);
        fire(2, 15);
        reti_pulse();
        repeat (12) @(posedge clk);
        check(16'(call_cnt), 16'h000F);
        vec_q.push_back(16'h0003);
        auto_reti <= 1'b1;
        reti_pulse();
        wait_calls(16);
        $display("test nesting done");
        // low-level mode on ext0 keeps asking while held low
        wr(8'h88, 8'h04);
        vec_q.push_back(16'h0003);
        vec_q.push_back(16'h0003);
        src_on[0] <= 1'b1;
        wait_calls(18);
        src_on[0] <= 1'b0;
        wr(8'hA8, 8'h00);
        repeat (20) @(posedge clk);
        check(16'(call_cnt), 16'h0012);
        $display("test level done");
        // ce low must freeze state, then a reset mid-run clears it again
        wr(8'h87, 8'h0C);
        @(posedge clk);
        ce        <= 1'b0;
        sfr_addr  <= 8'h87;
        sfr_wdata <= 8'h03;
        sfr_wr    <= 1'b1;
        repeat (3) @(posedge clk);
        sfr_wr    <= 1'b0;
        ce        <= 1'b1;
        rd(8'h87, 8'h0C);
        check({15'h0000, idle_mode}, 16'h0000);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd(8'h87, 8'h00);
        $display("test freeze done");
        repeat (4) @(posedge clk);
        print_verdict();
    end

    // watchdog well beyond the several hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
endmodule // cipc_ctrl_test

// ### verilog/cipc_ctrl.sv
`timescale 1ns/1ps
module cipc_ctrl
    import cipc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        ce,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic [7:0]  sfr_wdata,
    input  wire logic        sfr_rd,
    output logic      [7:0]  sfr_rdata,
    input  wire logic        timer0_ovf,
    input  wire logic        timer1_ovf,
    input  wire logic        ext0_n,
    input  wire logic        ext1_n,
    input  wire logic        ext2_pin,
    input  wire logic        ext3_pin,
    input  wire logic        ext4_in,
    input  wire logic        ext5_in,
    input  wire logic        ext6_in,
    input  wire logic        serial0_flag,
    input  wire logic        serial1_flag,
    input  wire logic        instr_end,
    input  wire logic        core_reti,
    output logic             irq_call,
    output logic      [15:0] irq_vector,
    output logic             baud_double,
    output logic             stop_mode,
    output logic             idle_mode
);
    import cipc_pkg::*;

    typedef struct packed {
        logic [7:0]            cpu_power_control;
        logic [7:0]            timer_and_ext_irq_control;
        logic [7:0]            irq_enable_main;
        logic [7:0]            irq_enable_external;
        logic [7:0]            irq_enable_serial1;
        logic [7:0]            ip0;
        logic [7:0]            ip1;
        logic [7:0]            t2con;
        logic [7:0]            irq_request_flags;
        logic [6:0]            ext_prev;
        logic [CIPC_N_SRC-1:0] pend;
        cipc_fsm_t             fsm;
        logic                  req;
        logic [3:0]            req_idx;
        logic [1:0]            req_lvl;
        logic [3:0]            insvc;
        logic [2:0]            call_cnt;
        logic                  call_active;
        logic [15:0]           vec;
        logic [7:0]            rdata;
    } cipc_state_t;

    cipc_state_t           s_reg;
    cipc_state_t           s_next;
    logic [6:0]            ext_in;
    logic [6:0]            ext_rise;
    logic [6:0]            ext_fall;
    logic [CIPC_N_SRC-1:0] src_flag;
    logic [CIPC_N_SRC-1:0] src_en;
    logic [CIPC_N_SRC-1:0] pend_calc;
    logic [1:0]            src_lvl [CIPC_N_SRC];
    logic [1:0]            cur_lvl;
    logic                  found;
    logic [3:0]            best_idx;
    logic [1:0]            best_lvl;
    logic                  best_ok;
    logic                  call_start;

    // edge detection against the previous machine cycle
    assign ext_in   = {ext6_in, ext5_in, ext4_in, ext3_pin, ext2_pin, ext1_n, ext0_n};
    assign ext_rise = ext_in & ~s_reg.ext_prev;
    assign ext_fall = ~ext_in & s_reg.ext_prev;

    // flags and enables gathered in polling order
    assign src_flag = {s_reg.irq_request_flags[5], s_reg.irq_request_flags[4], serial0_flag, s_reg.irq_request_flags[3],
                       s_reg.timer_and_ext_irq_control[7], s_reg.irq_request_flags[2], s_reg.timer_and_ext_irq_control[3], s_reg.irq_request_flags[1],
                       s_reg.timer_and_ext_irq_control[5], serial1_flag, s_reg.timer_and_ext_irq_control[1]};
    assign src_en   = {s_reg.irq_enable_external[5], s_reg.irq_enable_external[4], s_reg.irq_enable_main[4], s_reg.irq_enable_external[3],
                       s_reg.irq_enable_main[3], s_reg.irq_enable_external[2], s_reg.irq_enable_main[2], s_reg.irq_enable_external[1],
                       s_reg.irq_enable_main[1], s_reg.irq_enable_serial1[0], s_reg.irq_enable_main[0]};
    assign pend_calc = src_flag & src_en
                       & {CIPC_N_SRC{s_reg.irq_enable_main[CIPC_BIT_GLOBAL_EN]}};

    // level of each source from its group bit in both priority registers
    for (genvar i = 0; i < CIPC_N_SRC; i++) begin : g_lvl
        assign src_lvl[i] = {s_reg.ip1[i / 2], s_reg.ip0[i / 2]};
    end

    // highest level now in service; idle when no bit set
    assign cur_lvl = s_reg.insvc[3] ? 2'd3 : s_reg.insvc[2] ? 2'd2 :
                     s_reg.insvc[1] ? 2'd1 : 2'd0;

    // poll the samples: lowest index wins inside one level
    always_comb begin
        found    = 1'b0;
        best_idx = 4'h0;
        best_lvl = 2'd0;
        for (int i = CIPC_N_SRC - 1; i >= 0; i--) begin
            if (s_reg.pend[i] && (!found || src_lvl[i] >= best_lvl)) begin
                found    = 1'b1;
                best_idx = 4'(i);
                best_lvl = src_lvl[i];
            end
        end
        best_ok = found && (s_reg.insvc == 4'h0 || best_lvl > cur_lvl);
    end

    // a registered request is taken only at an instruction boundary
    assign call_start = (s_reg.fsm == CIPC_POLL) && s_reg.req && instr_end
                        && (s_reg.insvc == 4'h0 || s_reg.req_lvl > cur_lvl);

    always_comb begin
        s_next = s_reg;
        // register writes; reserved bits never stored
        if (sfr_wr) begin
            if (sfr_addr == CIPC_ADDR_POWER) begin
                s_next.cpu_power_control = sfr_wdata & CIPC_MASK_POWER;
            end else if (sfr_addr == CIPC_ADDR_TCTL) begin
                s_next.timer_and_ext_irq_control = sfr_wdata & CIPC_MASK_TCTL;
            end else if (sfr_addr == CIPC_ADDR_IEN_SER1) begin
                s_next.irq_enable_serial1 = sfr_wdata & CIPC_MASK_IEN_SER1;
            end else if (sfr_addr == CIPC_ADDR_IEN_MAIN) begin
                s_next.irq_enable_main = sfr_wdata & CIPC_MASK_IEN_MAIN;
            end else if (sfr_addr == CIPC_ADDR_PRIO_LOW) begin
                s_next.ip0 = sfr_wdata & CIPC_MASK_PRIO;
            end else if (sfr_addr == CIPC_ADDR_IEN_EXT) begin
                s_next.irq_enable_external = sfr_wdata & CIPC_MASK_IEN_EXT;
            end else if (sfr_addr == CIPC_ADDR_PRIO_HIGH) begin
                s_next.ip1 = sfr_wdata & CIPC_MASK_PRIO;
            end else if (sfr_addr == CIPC_ADDR_REQ_FLAGS) begin
                s_next.irq_request_flags = sfr_wdata & CIPC_MASK_REQ_FLAGS;
            end else if (sfr_addr == CIPC_ADDR_EDGE_CTL) begin
                s_next.t2con = sfr_wdata & CIPC_MASK_EDGE_CTL;
            end
        end
        // registered read; unmapped addresses and reserved bits give zero
        if (sfr_rd) begin
            if (sfr_addr == CIPC_ADDR_POWER) begin
                s_next.rdata = s_reg.cpu_power_control;
            end else if (sfr_addr == CIPC_ADDR_TCTL) begin
                s_next.rdata = s_reg.timer_and_ext_irq_control;
            end else if (sfr_addr == CIPC_ADDR_IEN_SER1) begin
                s_next.rdata = s_reg.irq_enable_serial1;
            end else if (sfr_addr == CIPC_ADDR_IEN_MAIN) begin
                s_next.rdata = s_reg.irq_enable_main;
            end else if (sfr_addr == CIPC_ADDR_PRIO_LOW) begin
                s_next.rdata = s_reg.ip0;
            end else if (sfr_addr == CIPC_ADDR_IEN_EXT) begin
                s_next.rdata = s_reg.irq_enable_external;
            end else if (sfr_addr == CIPC_ADDR_PRIO_HIGH) begin
                s_next.rdata = s_reg.ip1;
            end else if (sfr_addr == CIPC_ADDR_REQ_FLAGS) begin
                s_next.rdata = s_reg.irq_request_flags;
            end else if (sfr_addr == CIPC_ADDR_EDGE_CTL) begin
                s_next.rdata = s_reg.t2con;
            end else begin
                s_next.rdata = CIPC_RESET_VALUE;
            end
        end
        // return from service drops the highest active level
        if (core_reti) begin
            s_next.insvc[cur_lvl] = 1'b0;
        end
        // once per machine cycle: sample enabled flags for the next poll
        s_next.pend     = pend_calc;
        s_next.ext_prev = ext_in;
        case (s_reg.fsm)
            CIPC_POLL: begin
                s_next.req     = best_ok;
                s_next.req_idx = best_idx;
                s_next.req_lvl = best_lvl;
                if (call_start) begin
                    s_next.fsm         = CIPC_CALL;
                    s_next.call_cnt    = CIPC_CALL_LAST;
                    s_next.call_active = 1'b1;
                    s_next.vec         = CIPC_VEC[s_reg.req_idx];
                    s_next.req         = 1'b0;
                    s_next.insvc[s_reg.req_lvl] = 1'b1;
                    // any taken interrupt ends idle; ext0 also wakes from stop
                    s_next.cpu_power_control[CIPC_BIT_IDLE] = 1'b0;
                    if (s_reg.req_idx == 4'(CIPC_SRC_EXT0)) begin
                        s_next.cpu_power_control[CIPC_BIT_STOP] = 1'b0;
                    end
                    // auto-clear the flag of the taken timer or external source
                    case (s_reg.req_idx)
                        4'(CIPC_SRC_EXT0): s_next.timer_and_ext_irq_control[CIPC_BIT_EXT0_FLAG] = 1'b0;
                        4'(CIPC_SRC_TMR0): s_next.timer_and_ext_irq_control[CIPC_BIT_TIMER0_FLAG] = 1'b0;
                        4'(CIPC_SRC_EXT1): s_next.timer_and_ext_irq_control[CIPC_BIT_EXT1_FLAG] = 1'b0;
                        4'(CIPC_SRC_TMR1): s_next.timer_and_ext_irq_control[CIPC_BIT_TIMER1_FLAG] = 1'b0;
                        4'(CIPC_SRC_EXT2): s_next.irq_request_flags[1] = 1'b0;
                        4'(CIPC_SRC_EXT3): s_next.irq_request_flags[2] = 1'b0;
                        4'(CIPC_SRC_EXT4): s_next.irq_request_flags[3] = 1'b0;
                        4'(CIPC_SRC_EXT5): s_next.irq_request_flags[4] = 1'b0;
                        4'(CIPC_SRC_EXT6): s_next.irq_request_flags[5] = 1'b0;
                        default: ;
                    endcase
                end
            end
            CIPC_CALL: begin
                // the forced call occupies the core for its six cycles
                s_next.req = 1'b0;
                if (s_reg.call_cnt == 3'h0) begin
                    s_next.fsm         = CIPC_POLL;
                    s_next.call_active = 1'b0;
                end else begin
                    s_next.call_cnt = s_reg.call_cnt - 3'h1;
                end
            end
            default: begin
                s_next.fsm = CIPC_POLL;
            end
        endcase
        // hardware sets come last so an event beats a same-cycle clear
        if (timer0_ovf) begin
            s_next.timer_and_ext_irq_control[CIPC_BIT_TIMER0_FLAG] = 1'b1;
        end
        if (timer1_ovf) begin
            s_next.timer_and_ext_irq_control[CIPC_BIT_TIMER1_FLAG] = 1'b1;
        end
        // low level keeps re-setting the flag while the pin stays low
        if (s_reg.timer_and_ext_irq_control[CIPC_BIT_EXT0_TYPE] ? ext_fall[0] : !ext0_n) begin
            s_next.timer_and_ext_irq_control[CIPC_BIT_EXT0_FLAG] = 1'b1;
        end
        if (s_reg.timer_and_ext_irq_control[CIPC_BIT_EXT1_TYPE] ? ext_fall[1] : !ext1_n) begin
            s_next.timer_and_ext_irq_control[CIPC_BIT_EXT1_FLAG] = 1'b1;
        end
        if (s_reg.t2con[CIPC_BIT_EXT2_EDGE] ? ext_rise[2] : ext_fall[2]) begin
            s_next.irq_request_flags[1] = 1'b1;
        end
        if (s_reg.t2con[CIPC_BIT_EXT3_EDGE] ? ext_rise[3] : ext_fall[3]) begin
            s_next.irq_request_flags[2] = 1'b1;
        end
        // peripheral groups present rising edges
        s_next.irq_request_flags[5:3] = s_next.irq_request_flags[5:3] | ext_rise[6:4];
    end

    // one register stage; ce low freezes everything, but srst still clears it
    always_ff @(posedge clk) begin
        if (srst) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign sfr_rdata   = s_reg.rdata;
    assign irq_call    = s_reg.call_active;
    assign irq_vector  = s_reg.vec;
    assign baud_double = s_reg.cpu_power_control[CIPC_BIT_BAUD_DOUBLE];
    assign stop_mode   = s_reg.cpu_power_control[CIPC_BIT_STOP];
    assign idle_mode   = s_reg.cpu_power_control[CIPC_BIT_IDLE];

    default clocking cb @(posedge clk iff ce);
    endclocking
    default disable iff (srst);

    sequence call_begin_s;
        $rose(s_reg.call_active);
    endsequence
    sequence call_body_s;
        s_reg.call_active [*6] ##1 !s_reg.call_active;
    endsequence

    chk_call_length: assert property (call_begin_s |-> call_body_s)
        else $error("forced call not six cycles");
    chk_call_vector: assert property (call_start |=> irq_vector == CIPC_VEC[$past(s_reg.req_idx)])
        else $error("wrong vector on forced call");
    chk_global_gate: assert property (!s_reg.irq_enable_main[7] |-> ##2 !s_reg.req)
        else $error("request with global enable low");
    chk_sample_pend: assert property (1'b1 |=> s_reg.pend == $past(pend_calc))
        else $error("pending sample not taken");
    chk_no_preempt:  assert property (s_reg.insvc[3] |-> !call_start)
        else $error("preempted top level service");
    chk_reti_pop:    assert property (core_reti && s_reg.insvc == 4'h1 |=> s_reg.insvc == 4'h0)
        else $error("return did not end service");
    chk_ext0_edge:   assert property (s_reg.timer_and_ext_irq_control[0] && ext_fall[0] |=> s_reg.timer_and_ext_irq_control[1])
        else $error("ext0 edge flag not set");
    chk_ext1_level:  assert property (!s_reg.timer_and_ext_irq_control[2] && !ext1_n |=> s_reg.timer_and_ext_irq_control[3])
        else $error("ext1 level flag not set");
    chk_tmr0_clear:  assert property (call_start && s_reg.req_idx == 4'h2 && !timer0_ovf
                                      |=> !s_reg.timer_and_ext_irq_control[5])
        else $error("timer0 flag not cleared");
    chk_baud_write:  assert property (sfr_wr && sfr_addr == CIPC_ADDR_POWER
                                      |=> baud_double == $past(sfr_wdata[7]))
        else $error("baud double bit not written");
endmodule // cipc_ctrl

// ### verilog/cipc_pkg.sv
package cipc_pkg;
    // special-function addresses on the core's internal port
    localparam logic [7:0] CIPC_ADDR_POWER     = 8'h87;
    localparam logic [7:0] CIPC_ADDR_TCTL      = 8'h88;
    localparam logic [7:0] CIPC_ADDR_IEN_SER1  = 8'h9A;
    localparam logic [7:0] CIPC_ADDR_IEN_MAIN  = 8'hA8;
    localparam logic [7:0] CIPC_ADDR_PRIO_LOW  = 8'hA9;
    localparam logic [7:0] CIPC_ADDR_IEN_EXT   = 8'hB8;
    localparam logic [7:0] CIPC_ADDR_PRIO_HIGH = 8'hB9;
    localparam logic [7:0] CIPC_ADDR_REQ_FLAGS = 8'hC0;
    localparam logic [7:0] CIPC_ADDR_EDGE_CTL  = 8'hC8;
    // implemented bits per register, reserved bits stay zero
    localparam logic [7:0] CIPC_MASK_POWER     = 8'h8F;
    localparam logic [7:0] CIPC_MASK_TCTL      = 8'hFF;
    localparam logic [7:0] CIPC_MASK_IEN_SER1  = 8'h01;
    localparam logic [7:0] CIPC_MASK_IEN_MAIN  = 8'hDF;
    localparam logic [7:0] CIPC_MASK_PRIO      = 8'h3F;
    localparam logic [7:0] CIPC_MASK_IEN_EXT   = 8'h7E;
    localparam logic [7:0] CIPC_MASK_REQ_FLAGS = 8'h3E;
    localparam logic [7:0] CIPC_MASK_EDGE_CTL  = 8'h60;
    localparam logic [7:0] CIPC_RESET_VALUE    = 8'h00;
    // field positions
    localparam int CIPC_BIT_BAUD_DOUBLE   = 7;
    localparam int CIPC_BIT_STOP          = 1;
    localparam int CIPC_BIT_IDLE          = 0;
    localparam int CIPC_BIT_GLOBAL_EN     = 7;
    localparam int CIPC_BIT_TIMER1_FLAG   = 7;
    localparam int CIPC_BIT_TIMER0_FLAG   = 5;
    localparam int CIPC_BIT_EXT1_FLAG     = 3;
    localparam int CIPC_BIT_EXT1_TYPE     = 2;
    localparam int CIPC_BIT_EXT0_FLAG     = 1;
    localparam int CIPC_BIT_EXT0_TYPE     = 0;
    localparam int CIPC_BIT_EXT2_EDGE     = 5;
    localparam int CIPC_BIT_EXT3_EDGE     = 6;
    // sources in polling order; group of a source is its index halved
    localparam int CIPC_N_SRC    = 11;
    localparam int CIPC_SRC_EXT0 = 0;
    localparam int CIPC_SRC_TMR0 = 2;
    localparam int CIPC_SRC_EXT2 = 3;
    localparam int CIPC_SRC_EXT1 = 4;
    localparam int CIPC_SRC_EXT3 = 5;
    localparam int CIPC_SRC_TMR1 = 6;
    localparam int CIPC_SRC_EXT4 = 7;
    localparam int CIPC_SRC_EXT5 = 9;
    localparam int CIPC_SRC_EXT6 = 10;
    // vectors indexed by polling position
    localparam logic [15:0] CIPC_VEC [0:CIPC_N_SRC-1] = '{
        16'h0003, 16'h0083, 16'h000B, 16'h004B, 16'h0013, 16'h0053,
        16'h001B, 16'h005B, 16'h0023, 16'h0063, 16'h006B};
    // forced call timing in machine cycles
    localparam int CIPC_DETECT_CYCLES = 1;
    localparam int CIPC_CALL_CYCLES   = 6;
    localparam int CIPC_MIN_LATENCY   = CIPC_DETECT_CYCLES + CIPC_CALL_CYCLES;
    localparam logic [2:0] CIPC_CALL_LAST = 3'(CIPC_CALL_CYCLES - 1);
    typedef enum logic [0:0] {
        CIPC_POLL = 1'b0,
        CIPC_CALL = 1'b1
    } cipc_fsm_t;
endpackage
